// ==== core/sgc_switch_global_control_regs.sv ====
/*
 * Global switch control register bank: VLAN mode, output queue priority
 * scheme, mirroring match mode, switch MII port duplex, flow control and
 * speed, and null VLAN ID substitution, plus the small datapath decisions
 * that these settings steer.
 * Assumes a synchronous management register port and strap pins that are
 * stable around the release of reset.
 */
// Functional notes
// R1: Bit 7 of the first register turns 802.1Q VLAN mode on when 1 and resets to 0.
// R2: Software fills the VLAN table before it sets the VLAN enable bit.
// R3: With VLAN enable at 0, VLAN membership does not limit forwarding.
// R4: Priority scheme 00, the reset value, always sends high priority packets first.
// R5: Scheme codes 01, 10 and 11 interleave high and low packets at 10:1, 5:1 and 2:1.
// R6: Mirror mode bit at 1 mirrors a frame only when source and destination both match.
// R7: Mirror mode bit at 0, the default, mirrors a frame when either port matches.
// R8: Bit 6 of the second register selects MII half duplex at 1, reset taken from its strap.
// R9: Bit 5 enables MII full duplex flow control at 1, reset taken from its strap.
// R10: Bit 4 runs the MII port at 10 Mbps at 1 and 100 Mbps at 0, reset from its strap.
// R11: Bit 3 at 1 replaces a null VLAN ID in tagged frames with the port default VLAN ID.
// R12: Bit 3 at 0, its reset value, leaves a null VLAN ID unchanged.
// R13: Reserved bits reset to 0, read back as written and steer nothing.
module sgc_switch_global_control_regs
  import sgc_pkg::*;
#(
  parameter int VID_W = SGC_VID_W
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic duplex_strap_pin_i,
  input wire logic flow_ctrl_strap_pin_i,
  input wire logic speed_strap_pin_i,
  input wire logic vlan_member_i,
  input wire logic hi_pending_i,
  input wire logic lo_pending_i,
  input wire logic sched_take_i,
  input wire logic mirror_src_match_i,
  input wire logic mirror_dst_match_i,
  input wire logic rx_tagged_i,
  input wire logic [VID_W-1:0] rx_vid_i,
  input wire logic [VID_W-1:0] port_default_vid_i,
  output logic vlan_mode_o,
  output logic forward_ok_o,
  output logic sched_pick_hi_o,
  output logic sched_pick_valid_o,
  output logic mirror_o,
  output logic mii_half_duplex_o,
  output logic mii_flow_ctrl_o,
  output logic mii_speed_10_o,
  output logic [VID_W-1:0] vid_out_o
);

  // ----------------------------------------------------------------------
  // Register file and strap capture
  // ----------------------------------------------------------------------
  sgc_state_t state_reg, state_next;
  logic [7:0] vpm_reg, vpm_next;
  logic [7:0] mvc_reg, mvc_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb
  begin
    state_next = state_reg;
    vpm_next = vpm_reg;
    mvc_next = mvc_reg;
    rdata_next = rdata_reg;
    case (state_reg)
      SGC_ST_STRAP:
      begin
        // Straps are caught on the first edge after reset is released.
        mvc_next[SGC_MVC_HALF_DUPLEX] = duplex_strap_pin_i; // [R8]
        mvc_next[SGC_MVC_FLOW_CTRL] = flow_ctrl_strap_pin_i; // [R9]
        mvc_next[SGC_MVC_SPEED_10] = speed_strap_pin_i; // [R10]
        state_next = SGC_ST_RUN;
      end
      SGC_ST_RUN:
      begin
        // Whole bytes are stored, reserved bits included.
        if (reg_wr_i && reg_addr_i == SGC_OFS_VPM)
        begin
          vpm_next = reg_wdata_i; // [R1] [R13]
        end
        if (reg_wr_i && reg_addr_i == SGC_OFS_MVC)
        begin
          mvc_next = reg_wdata_i; // [R13]
        end
        if (reg_rd_i)
        begin
          case (reg_addr_i)
            SGC_OFS_VPM: rdata_next = vpm_reg;
            SGC_OFS_MVC: rdata_next = mvc_reg;
            default: rdata_next = SGC_RDATA_UNMAPPED;
          endcase
        end
      end
      default:
      begin
        state_next = SGC_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= SGC_ST_STRAP;
      vpm_reg <= SGC_VPM_RESET; // [R1] [R4] [R7] [R13]
      mvc_reg <= SGC_MVC_RESET; // [R12] [R13]
      rdata_reg <= SGC_RDATA_UNMAPPED;
    end
    else
    begin
      state_reg <= state_next;
      vpm_reg <= vpm_next;
      mvc_reg <= mvc_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------------
  // Output queue scheduler
  // ----------------------------------------------------------------------
  sgc_prio_t prio;
  logic [3:0] ratio;
  logic [3:0] hi_cnt_reg, hi_cnt_next;
  logic pick_hi_reg, pick_hi_next;
  logic pick_valid_reg, pick_valid_next;

  assign prio = sgc_prio_t'(vpm_reg[SGC_VPM_PRIO_HI:SGC_VPM_PRIO_LO]);

  always_comb
  begin
    case (prio)
      SGC_PRIO_10_1: ratio = SGC_RATIO_10; // [R5]
      SGC_PRIO_5_1: ratio = SGC_RATIO_5; // [R5]
      SGC_PRIO_2_1: ratio = SGC_RATIO_2; // [R5]
      default: ratio = SGC_CNT_ZERO;
    endcase
  end

  always_comb
  begin
    hi_cnt_next = hi_cnt_reg;
    // A taken slot consumes the decision that was offered.
    if (sched_take_i && pick_valid_reg)
    begin
      if (pick_hi_reg)
      begin
        hi_cnt_next = (hi_cnt_reg < SGC_RATIO_10) ? hi_cnt_reg + SGC_CNT_ONE : hi_cnt_reg;
      end
      else
      begin
        hi_cnt_next = SGC_CNT_ZERO;
      end
    end
    pick_valid_next = hi_pending_i || lo_pending_i;
    if (hi_pending_i && lo_pending_i)
    begin
      pick_hi_next = (prio == SGC_PRIO_STRICT) || (hi_cnt_next < ratio); // [R4] [R5]
    end
    else
    begin
      pick_hi_next = hi_pending_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hi_cnt_reg <= SGC_CNT_ZERO;
      pick_hi_reg <= 1'b0;
      pick_valid_reg <= 1'b0;
    end
    else
    begin
      hi_cnt_reg <= hi_cnt_next;
      pick_hi_reg <= pick_hi_next;
      pick_valid_reg <= pick_valid_next;
    end
  end

  assign sched_pick_hi_o = pick_hi_reg;
  assign sched_pick_valid_o = pick_valid_reg;

  // ----------------------------------------------------------------------
  // Forwarding, mirroring and VLAN ID decisions
  // ----------------------------------------------------------------------
  logic fwd_reg, fwd_next;
  logic mirror_reg, mirror_next;
  logic [VID_W-1:0] vid_reg, vid_next;

  always_comb
  begin
    fwd_next = !vpm_reg[SGC_VPM_VLAN_EN] || vlan_member_i; // [R1] [R3]
    if (vpm_reg[SGC_VPM_SNIFF_AND])
    begin
      mirror_next = mirror_src_match_i && mirror_dst_match_i; // [R6]
    end
    else
    begin
      mirror_next = mirror_src_match_i || mirror_dst_match_i; // [R7]
    end
    vid_next = rx_vid_i; // [R12]
    if (mvc_reg[SGC_MVC_NULL_VID_SUB] && rx_tagged_i && rx_vid_i == SGC_NULL_VID)
    begin
      vid_next = port_default_vid_i; // [R11]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fwd_reg <= 1'b0;
      mirror_reg <= 1'b0;
      vid_reg <= '0;
    end
    else
    begin
      fwd_reg <= fwd_next;
      mirror_reg <= mirror_next;
      vid_reg <= vid_next;
    end
  end

  assign forward_ok_o = fwd_reg;
  assign mirror_o = mirror_reg;
  assign vid_out_o = vid_reg;
  assign vlan_mode_o = vpm_reg[SGC_VPM_VLAN_EN];
  assign mii_half_duplex_o = mvc_reg[SGC_MVC_HALF_DUPLEX];
  assign mii_flow_ctrl_o = mvc_reg[SGC_MVC_FLOW_CTRL];
  assign mii_speed_10_o = mvc_reg[SGC_MVC_SPEED_10];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_VLAN_FWD: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R3]
    !vpm_reg[SGC_VPM_VLAN_EN] |=> forward_ok_o)
    else $error("Forwarding blocked while VLAN mode is off.");
  AST_VLAN_WR: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R1]
    state_reg == SGC_ST_RUN && reg_wr_i && reg_addr_i == SGC_OFS_VPM
    |=> vlan_mode_o == $past(reg_wdata_i[SGC_VPM_VLAN_EN]))
    else $error("VLAN mode does not follow the written bit.");
  AST_STRICT: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    prio == SGC_PRIO_STRICT && hi_pending_i |=> sched_pick_hi_o)
    else $error("Low packet picked ahead of high in strict mode.");
  AST_RATIO_LO: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    prio != SGC_PRIO_STRICT && hi_pending_i && lo_pending_i && hi_cnt_next >= ratio
    |=> sched_pick_valid_o && !sched_pick_hi_o)
    else $error("Low packet not given its share.");
  AST_MIRROR_AND: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R6]
    vpm_reg[SGC_VPM_SNIFF_AND] && !(mirror_src_match_i && mirror_dst_match_i) |=> !mirror_o)
    else $error("Mirrored without both matches.");
  AST_MIRROR_OR: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R7]
    !vpm_reg[SGC_VPM_SNIFF_AND] && (mirror_src_match_i || mirror_dst_match_i) |=> mirror_o)
    else $error("Frame not mirrored on a single match.");
  AST_STRAP: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R8]
    state_reg == SGC_ST_STRAP |=> mii_half_duplex_o == $past(duplex_strap_pin_i)
    && mii_flow_ctrl_o == $past(flow_ctrl_strap_pin_i)
    && mii_speed_10_o == $past(speed_strap_pin_i))
    else $error("Strap values not captured."); // [R9] [R10]
  AST_NULL_SUB: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
    mvc_reg[SGC_MVC_NULL_VID_SUB] && rx_tagged_i && rx_vid_i == SGC_NULL_VID
    |=> vid_out_o == $past(port_default_vid_i))
    else $error("Null VLAN ID not replaced.");
  AST_NULL_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R12]
    !mvc_reg[SGC_MVC_NULL_VID_SUB] |=> vid_out_o == $past(rx_vid_i))
    else $error("VLAN ID changed with substitution off.");
  AST_READBACK: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R13]
    state_reg == SGC_ST_RUN && reg_wr_i && reg_addr_i == SGC_OFS_MVC ##1
    reg_rd_i && !reg_wr_i && reg_addr_i == SGC_OFS_MVC |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("Register does not read back as written.");

  COV_RATIO: cover property (@(posedge clk_i) disable iff (!resetn_i)
    prio == SGC_PRIO_2_1 && sched_take_i && pick_valid_reg && !pick_hi_reg);
  COV_MIRROR_AND: cover property (@(posedge clk_i) disable iff (!resetn_i)
    vpm_reg[SGC_VPM_SNIFF_AND] && mirror_o);
  COV_SUB: cover property (@(posedge clk_i) disable iff (!resetn_i)
    mvc_reg[SGC_MVC_NULL_VID_SUB] && rx_tagged_i && rx_vid_i == SGC_NULL_VID);

endmodule

// ==== include/sgc_pkg.sv ====
/*
 * Constants for the global switch control register bank: register offsets,
 * field positions, reset values and scheduler ratios.
 * Assumes an 8-bit management register port with byte-wide offsets.
 */
package sgc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] SGC_OFS_VPM = 8'h05;
  localparam logic [7:0] SGC_OFS_MVC = 8'h06;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SGC_VPM_VLAN_EN = 7;
  localparam int SGC_VPM_PRIO_HI = 3;
  localparam int SGC_VPM_PRIO_LO = 2;
  localparam int SGC_VPM_SNIFF_AND = 0;
  localparam int SGC_MVC_HALF_DUPLEX = 6;
  localparam int SGC_MVC_FLOW_CTRL = 5;
  localparam int SGC_MVC_SPEED_10 = 4;
  localparam int SGC_MVC_NULL_VID_SUB = 3;

  // ----------------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------------
  localparam logic [7:0] SGC_VPM_RESET = 8'h00;
  localparam logic [7:0] SGC_MVC_RESET = 8'h00;
  localparam logic [7:0] SGC_RDATA_UNMAPPED = 8'h00;
  localparam int SGC_VID_W = 12;
  localparam logic [11:0] SGC_NULL_VID = 12'h000;

  // ----------------------------------------------------------------------
  // Priority scheme codes and high-to-low ratios
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SGC_PRIO_STRICT = 2'h0,
    SGC_PRIO_10_1 = 2'h1,
    SGC_PRIO_5_1 = 2'h2,
    SGC_PRIO_2_1 = 2'h3
  } sgc_prio_t;

  localparam logic [3:0] SGC_RATIO_10 = 4'hA;
  localparam logic [3:0] SGC_RATIO_5 = 4'h5;
  localparam logic [3:0] SGC_RATIO_2 = 4'h2;
  localparam logic [3:0] SGC_CNT_ONE = 4'h1;
  localparam logic [3:0] SGC_CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------------
  // Strap capture states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SGC_ST_STRAP = 2'h1,
    SGC_ST_RUN = 2'h2
  } sgc_state_t;

endpackage

// ==== verification/sgc_bench.sv ====
/*
 * Self-checking bench for the global switch control register bank.
 * Assumes the bank's checks sit in the design and that inputs are driven at the falling edge.
 */
module sgc_bench
  import sgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] strap = 3'h0;
  logic [8:0] dp = 9'h000;
  logic [SGC_VID_W-1:0] rx_vid_i = 12'h000;
  logic [SGC_VID_W-1:0] port_default_vid_i = 12'h000;
  logic [7:0] reg_rdata_o;
  logic [SGC_VID_W-1:0] vid_out_o;
  logic vlan_mode_o, forward_ok_o, sched_pick_hi_o, sched_pick_valid_o, mirror_o;
  logic mii_half_duplex_o, mii_flow_ctrl_o, mii_speed_10_o;
  int bad_count = 0;
  int samples_checked = 0;
  int m_cnt;
  int rat;
  logic [7:0] m_vpm, m_mvc, m_rd;
  logic m_hi, m_val;
  logic [15:0] lfsr = 16'h0014;

  sgc_switch_global_control_regs sgc_switch_global_control_regs_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .duplex_strap_pin_i(strap[2]), .flow_ctrl_strap_pin_i(strap[1]),
    .speed_strap_pin_i(strap[0]), .vlan_member_i(dp[0]), .hi_pending_i(dp[1]),
    .lo_pending_i(dp[2]), .sched_take_i(dp[3]), .mirror_src_match_i(dp[4]),
    .mirror_dst_match_i(dp[5]), .rx_tagged_i(dp[6]), .rx_vid_i(rx_vid_i),
    .port_default_vid_i(port_default_vid_i), .vlan_mode_o(vlan_mode_o),
    .forward_ok_o(forward_ok_o), .sched_pick_hi_o(sched_pick_hi_o),
    .sched_pick_valid_o(sched_pick_valid_o), .mirror_o(mirror_o),
    .mii_half_duplex_o(mii_half_duplex_o), .mii_flow_ctrl_o(mii_flow_ctrl_o),
    .mii_speed_10_o(mii_speed_10_o), .vid_out_o(vid_out_o));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // ----------------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (e !== g)
    begin
      bad_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (e !== g)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_vid(input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (e !== g)
    begin
      bad_count++;
      $display("BAD vid_out expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_regs();
    chk_bit("vlan_mode", m_vpm[SGC_VPM_VLAN_EN], vlan_mode_o);
    chk_bit("half_duplex", m_mvc[SGC_MVC_HALF_DUPLEX], mii_half_duplex_o);
    chk_bit("flow_ctrl", m_mvc[SGC_MVC_FLOW_CTRL], mii_flow_ctrl_o);
    chk_bit("speed_10", m_mvc[SGC_MVC_SPEED_10], mii_speed_10_o);
    chk_byte("rdata", m_rd, reg_rdata_o);
  endtask

  // ----------------------------------------------------------------------
  // One clock of stimulus, reference model update and comparison
  // ----------------------------------------------------------------------
  task automatic step(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    logic m_fwd, m_mir;
    logic [11:0] m_vid;
    lfsr = lfsr_next(lfsr);
    reg_wr_i = wr;
    reg_rd_i = rd;
    reg_addr_i = a;
    reg_wdata_i = d;
    // A write edge gets inputs whose results do not depend on the old or new settings.
    dp = wr ? 9'h001 : {2'b00, lfsr[9], lfsr[8:7], lfsr[6] | lfsr[5],
      lfsr[4] | lfsr[3], lfsr[2] | lfsr[1] | lfsr[11], lfsr[0]};
    rx_vid_i = lfsr[10] ? 12'h000 : {4'h3, lfsr[15:8]};
    port_default_vid_i = {lfsr[15:12], lfsr[7:0]};
    @(posedge clk_i);
    if (rd)
      m_rd = (a == SGC_OFS_VPM) ? m_vpm : (a == SGC_OFS_MVC) ? m_mvc : SGC_RDATA_UNMAPPED;
    m_fwd = !m_vpm[SGC_VPM_VLAN_EN] | dp[0];
    m_mir = m_vpm[SGC_VPM_SNIFF_AND] ? (dp[4] & dp[5]) : (dp[4] | dp[5]);
    m_vid = (dp[6] && rx_vid_i == SGC_NULL_VID && m_mvc[SGC_MVC_NULL_VID_SUB]) ?
      port_default_vid_i : rx_vid_i;
    if (dp[3] && m_val)
      m_cnt = m_hi ? ((m_cnt < 10) ? m_cnt + 1 : 10) : 0;
    case (m_vpm[SGC_VPM_PRIO_HI:SGC_VPM_PRIO_LO])
      2'h1: rat = 10;
      2'h2: rat = 5;
      2'h3: rat = 2;
      default: rat = 0;
    endcase
    m_val = dp[1] | dp[2];
    m_hi = dp[1] && !(dp[2] && rat > 0 && m_cnt >= rat);
    if (wr && a == SGC_OFS_VPM)
      m_vpm = d;
    if (wr && a == SGC_OFS_MVC)
      m_mvc = d;
    @(negedge clk_i);
    chk_regs();
    chk_bit("forward_ok", m_fwd, forward_ok_o);
    chk_bit("mirror", m_mir, mirror_o);
    chk_vid(m_vid, vid_out_o);
    chk_bit("pick_valid", m_val, sched_pick_valid_o);
    chk_bit("pick_hi", m_hi, sched_pick_hi_o);
  endtask

  task automatic do_reset(input logic [2:0] s);
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    dp = 9'h000;
    strap = s;
    {m_vpm, m_mvc, m_rd, m_hi, m_val} = '0;
    m_cnt = 0;
    repeat (3) @(negedge clk_i);
    chk_regs();
    resetn_i = 1'b1;
    // A write in the strap cycle must be ignored.
    reg_wr_i = 1'b1;
    reg_addr_i = SGC_OFS_MVC;
    reg_wdata_i = 8'hFF;
    @(posedge clk_i);
    m_mvc = {1'b0, s, 4'h0};
    @(negedge clk_i);
    // Straps are sampled once, so flipping them now must not show.
    strap = ~s;
    chk_regs();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    do_reset(3'h0);
    step(1'b0, 1'b1, SGC_OFS_VPM, 8'h00);
    step(1'b0, 1'b1, SGC_OFS_MVC, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      step(1'b1, 1'b1, SGC_OFS_VPM, {k[0], lfsr[6:4], k[2:1], lfsr[1], k[0]});
      step(1'b1, 1'b1, SGC_OFS_MVC, lfsr[7:0] ^ {4'h0, k[0], 3'h0});
      step(1'b0, 1'b1, k[0] ? SGC_OFS_MVC : SGC_OFS_VPM, 8'h00);
      repeat (60) step(1'b0, 1'b0, 8'h00, 8'h00);
    end
    step(1'b1, 1'b0, 8'h07, 8'hFF);
    step(1'b1, 1'b1, 8'h00, 8'hA5);
    step(1'b0, 1'b1, 8'h07, 8'h00);
    do_reset(3'h7);
    step(1'b0, 1'b1, SGC_OFS_MVC, 8'h00);
    repeat (20) step(1'b0, 1'b0, 8'h00, 8'h00);
    wrap_up();
  end
endmodule
